// ---- verilog/ufc_pkg.sv ----
/*
 * Shared constants and types of the USB function device-control block:
 * register indices, field positions, reset values, link event carrier.
 * Assumes a 32-bit AHB-Lite register bus; each register is one word.
 */
package ufc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] UFC_IDX_FUNC_ADDR = 8'h00;
    localparam logic [7:0] UFC_IDX_POWER     = 8'h01;
    localparam logic [7:0] UFC_IDX_IRQ_FLAGS = 8'h02;
    localparam logic [7:0] UFC_IDX_IRQ_EN    = 8'h07;
    localparam logic [7:0] UFC_IDX_EP_INDEX  = 8'h0e;
    localparam logic [7:0] UFC_IDX_FIFO_LO   = 8'h20;
    localparam logic [7:0] UFC_IDX_FIFO_HI   = 8'h23;

    // Address register fields
    localparam int UFC_FA_PENDING_BIT = 7;

    // Power register fields
    localparam int UFC_PW_ISO_SYNC  = 7;
    localparam int UFC_PW_INHIBIT   = 4;
    localparam int UFC_PW_BUS_RST   = 3;
    localparam int UFC_PW_RESUME    = 2;
    localparam int UFC_PW_SUSPENDED = 1;
    localparam int UFC_PW_SUSP_EN   = 0;

    // Interrupt flag and enable fields
    localparam int UFC_IRQ_SUSPEND = 0;
    localparam int UFC_IRQ_RESUME  = 1;
    localparam int UFC_IRQ_RESET   = 2;

    // Reset values
    localparam logic [6:0] UFC_ADDR_RST    = 7'h00;
    localparam logic [3:0] UFC_INDEX_RST   = 4'h0;
    localparam logic [2:0] UFC_IRQ_EN_RST  = 3'h6;
    localparam logic [2:0] UFC_IRQ_EN_BRST = 3'h6;
    localparam logic [2:0] UFC_IRQ_FL_RST  = 3'h0;

    // Endpoint FIFO shape
    localparam int UFC_NUM_EP     = 4;
    localparam int UFC_FIFO_DEPTH = 64;

    // AHB constants
    localparam logic [1:0] UFC_HTRANS_NONSEQ = 2'h2;
    localparam logic       UFC_HRESP_OKAY    = 1'h0;

    // Events reported by the serial engine on the bus side
    typedef struct packed {
        logic bus_reset;
        logic suspend;
        logic resume;
        logic sof;
        logic xfer_end;
    } ufc_evt_t;

    // IN token seen on the bus
    typedef struct packed {
        logic       valid;
        logic [1:0] ep;
    } ufc_tok_t;

endpackage

// ---- verilog/ufc_fifo.sv ----
/*
 * Byte FIFO with flush for one endpoint direction; read data registered.
 * Assumes push on full and pop on empty are ignored by design.
 */
module ufc_fifo
    import ufc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = UFC_FIFO_DEPTH
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] din,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] dout,
    output logic                  empty,
    output logic                  full
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    wp_nxt;
    logic [AW-1:0]    rp_r;
    logic [AW-1:0]    rp_nxt;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic [WIDTH-1:0] dout_nxt;
    logic             do_push;
    logic             do_pop;

    assign empty   = (cnt_r == '0);
    assign full    = (cnt_r == (AW+1)'(DEPTH));
    assign do_push = push && !full && !flush;
    assign do_pop  = pop && !empty && !flush;

    // Pointer and count update; flush wins over traffic
    always_comb
    begin
        wp_nxt   = wp_r;
        rp_nxt   = rp_r;
        cnt_nxt  = cnt_r;
        dout_nxt = dout;
        if (flush)
        begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end
        else
        begin
            if (do_push)
                wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            if (do_pop)
            begin
                rp_nxt   = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
                dout_nxt = mem[rp_r];
            end
            cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            dout  <= '0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            dout  <= dout_nxt;
        end
    end

    // Storage holds no reset; contents are meaningless once flushed
    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[wp_r] <= din;
    end

endmodule

// ---- verilog/ufc_device_ctrl.sv ----
/*
 * USB function device control: endpoint FIFO ports, deferred function
 * address, bus reset, suspend/resume, ISO update and controller inhibit,
 * all behind an AHB-Lite slave that answers with zero wait states.
 * Assumes the serial engine reports bus events on CLK, synchronous.
 */
// Contract
// R01 - Four consecutive indices 0x20..0x23 are FIFO ports for endpoints 0..3
// R02 - Port write loads IN FIFO; port read unloads OUT FIFO
// R03 - Firmware writes host-assigned 7-bit address on SET_ADDRESS
// R04 - Old address stays active until current transfer ends
// R05 - Pending flag bit 7 set on write, cleared when address takes effect
// R06 - Bus reset flag, power bit 3, set on bus reset signalling
// R07 - Bus reset clears address, index, flushes FIFOs, clears endpoint CSRs
// R08 - Bus reset enables all interrupts but suspend, clears flags, flags reset
// R09 - Writing 1 to bus reset flag forces controller reset
// R10 - Suspend entered when enabled and detected; suspend interrupt if enabled
// R11 - Suspend left on resume, bus reset or any reset; oscillator too
// R12 - Resume from bus exits suspend and flags resume interrupt if enabled
// R13 - Firmware holds force-resume for 10-15 ms then clears it
// R14 - ISO sync holds newly loaded ISO IN packets until next SOF
// R15 - IN token on held ISO endpoint before SOF gets zero-length packet
// R16 - Inhibit set after power-on; clearing it enables controller
// R17 - Inhibit set again only by power-on or forced controller reset
// R18 - Firmware brings up clock, reset, transceiver, config, then enable
// R19 - Resume signalling is driven while force-resume stays set from suspend
// R20 - Each port access moves exactly one byte
// R21 - Clock logic provides 48 MHz full speed or 6 MHz low speed
module ufc_device_ctrl
    import ufc_pkg::*;
#(
    parameter int FIFO_DEPTH = UFC_FIFO_DEPTH
)
(
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    input  wire logic                 HSEL,
    input  wire logic [31:0]          HADDR,
    input  wire logic [1:0]           HTRANS,
    input  wire logic                 HWRITE,
    input  wire logic [31:0]          HWDATA,
    input  wire logic                 HREADY,
    output logic                      HREADYOUT,
    output logic                      HRESP,
    output logic      [31:0]          HRDATA,
    input  wire ufc_evt_t             LINK_EVT,
    input  wire ufc_tok_t             IN_TOKEN,
    input  wire logic [3:0]           ISO_EP,
    input  wire logic [3:0]           PKT_LOADED,
    input  wire logic [3:0]           TX_POP,
    input  wire logic [3:0]           RX_PUSH,
    input  wire logic [7:0]           RX_DATA,
    output logic      [3:0][7:0]      TX_DATA,
    output logic      [3:0]           TX_EMPTY,
    output logic      [3:0]           RX_FULL,
    output logic      [6:0]           DEVICE_ADDR,
    output logic      [3:0]           EP_INDEX,
    output logic                      CTRL_ENABLE,
    output logic                      SUSPENDED,
    output logic                      OSC_SUSPEND,
    output logic                      RESUME_DRIVE,
    output logic                      EP_CSR_CLEAR,
    output logic      [3:0]           TX_HOLD,
    output logic                      ZLP_REPLY
);
    logic            soft_r;
    logic            usb_rst_n;
    logic            acc;
    logic [7:0]      idx;
    logic            idx_fifo;
    logic            wr_pend_r;
    logic [7:0]      wr_idx_r;
    logic            rd_fifo_r;
    logic [1:0]      rd_ep_r;
    logic [31:0]     rd_data_r;
    logic [31:0]     rd_data_nxt;
    logic [3:0]      bus_pop;
    logic [3:0]      bus_push;
    logic [3:0][7:0] out_q;
    logic            wr_fa;
    logic            wr_pw;
    logic [6:0]      addr_new_r;
    logic [6:0]      addr_new_nxt;
    logic [6:0]      addr_eff_r;
    logic [6:0]      addr_eff_nxt;
    logic            pend_r;
    logic            pend_nxt;
    logic            iso_r;
    logic            iso_nxt;
    logic            inh_r;
    logic            inh_nxt;
    logic            force_r;
    logic            force_nxt;
    logic            suspend_detect_enable_r;
    logic            suspend_detect_enable_nxt;
    logic            susp_r;
    logic            susp_nxt;
    logic            wake_r;
    logic            wake_nxt;
    logic            brst_r;
    logic            brst_evt;
    logic [3:0]      index_r;
    logic [3:0]      index_nxt;
    logic [2:0]      irq_en_r;
    logic [2:0]      irq_en_nxt;
    logic [2:0]      irq_fl_r;
    logic [2:0]      irq_fl_nxt;
    logic [2:0]      irq_set;
    logic [3:0]      held_r;
    logic [3:0]      held_nxt;
    logic            zlp_r;

    // Forced controller reset: a one-cycle pulse folded into the async reset
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            soft_r <= 1'b0;
        else
            soft_r <= wr_pw && HWDATA[UFC_PW_BUS_RST]; // [R09]
    end
    assign usb_rst_n = RESETN && !soft_r;

    // AHB-Lite address phase decode; never stalls, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP     = UFC_HRESP_OKAY;
    assign acc       = HSEL && HREADY && (HTRANS == UFC_HTRANS_NONSEQ);
    assign idx       = HADDR[9:2];
    assign idx_fifo  = (idx >= UFC_IDX_FIFO_LO) && (idx <= UFC_IDX_FIFO_HI);
    assign wr_fa     = wr_pend_r && (wr_idx_r == UFC_IDX_FUNC_ADDR);
    assign wr_pw     = wr_pend_r && (wr_idx_r == UFC_IDX_POWER);
    assign brst_evt  = LINK_EVT.bus_reset && !brst_r;

    // One pop per read, one push per write, only the addressed endpoint
    generate
        for (genvar e = 0; e < UFC_NUM_EP; e++)
        begin : g_ep
            assign bus_pop[e]  = acc && !HWRITE && idx_fifo &&
                                 (idx[1:0] == 2'(e)); // [R01] [R20]
            assign bus_push[e] = wr_pend_r &&
                                 (wr_idx_r >= UFC_IDX_FIFO_LO) &&
                                 (wr_idx_r <= UFC_IDX_FIFO_HI) &&
                                 (wr_idx_r[1:0] == 2'(e)); // [R02] [R20]
            ufc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_in
            (
                .clk   (CLK),
                .rst_n (usb_rst_n),
                .flush (brst_evt),
                .push  (bus_push[e]),
                .din   (HWDATA[7:0]),
                .pop   (TX_POP[e]),
                .dout  (TX_DATA[e]),
                .empty (TX_EMPTY[e]),
                .full  ()
            );
            ufc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_out
            (
                .clk   (CLK),
                .rst_n (usb_rst_n),
                .flush (brst_evt), // [R07]
                .push  (RX_PUSH[e]),
                .din   (RX_DATA),
                .pop   (bus_pop[e]), // [R02]
                .dout  (out_q[e]),
                .empty (),
                .full  (RX_FULL[e])
            );
        end
    endgenerate

    // Read data captured at the address phase, shown in the data phase
    always_comb
    begin
        rd_data_nxt = 32'h0;
        if (idx == UFC_IDX_FUNC_ADDR)
            rd_data_nxt = {24'h0, pend_r, addr_new_r};
        else if (idx == UFC_IDX_POWER)
            rd_data_nxt = {24'h0, iso_r, 2'h0, inh_r, brst_r, force_r,
                           susp_r, suspend_detect_enable_r};
        else if (idx == UFC_IDX_IRQ_FLAGS)
            rd_data_nxt = {29'h0, irq_fl_r};
        else if (idx == UFC_IDX_IRQ_EN)
            rd_data_nxt = {29'h0, irq_en_r};
        else if (idx == UFC_IDX_EP_INDEX)
            rd_data_nxt = {28'h0, index_r};
    end

    always_ff @(posedge CLK or negedge usb_rst_n)
    begin
        if (!usb_rst_n)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
            rd_fifo_r <= 1'b0;
            rd_ep_r   <= 2'h0;
            rd_data_r <= 32'h0;
        end
        else
        begin
            wr_pend_r <= acc && HWRITE;
            wr_idx_r  <= idx;
            rd_fifo_r <= acc && !HWRITE && idx_fifo;
            rd_ep_r   <= idx[1:0];
            rd_data_r <= acc ? rd_data_nxt : 32'h0;
        end
    end
    assign HRDATA = rd_fifo_r ? {24'h0, out_q[rd_ep_r]} : rd_data_r;

    // Address, power, index and interrupt state
    always_comb
    begin
        addr_new_nxt = addr_new_r;
        addr_eff_nxt = addr_eff_r;
        pend_nxt     = pend_r;
        iso_nxt      = iso_r;
        inh_nxt      = inh_r;
        force_nxt    = force_r;
        suspend_detect_enable_nxt    = suspend_detect_enable_r;
        index_nxt    = index_r;
        irq_en_nxt   = irq_en_r;
        irq_set      = 3'h0;
        // Deferred address: the new one takes effect at transfer end
        if (LINK_EVT.xfer_end && pend_r)
        begin
            addr_eff_nxt = addr_new_r; // [R04]
            pend_nxt     = 1'b0; // [R05]
        end
        if (wr_fa)
        begin
            addr_new_nxt = HWDATA[6:0];
            pend_nxt     = 1'b1; // [R05]
        end
        if (wr_pw)
        begin
            iso_nxt   = HWDATA[UFC_PW_ISO_SYNC];
            inh_nxt   = inh_r && HWDATA[UFC_PW_INHIBIT]; // [R16] [R17]
            force_nxt = HWDATA[UFC_PW_RESUME];
            suspend_detect_enable_nxt = HWDATA[UFC_PW_SUSP_EN];
        end
        if (wr_pend_r && (wr_idx_r == UFC_IDX_EP_INDEX))
            index_nxt = HWDATA[3:0];
        if (wr_pend_r && (wr_idx_r == UFC_IDX_IRQ_EN))
            irq_en_nxt = HWDATA[2:0];
        // Suspend: exits take priority over a fresh entry
        susp_nxt = susp_r;
        if (brst_evt || LINK_EVT.resume || (force_r && susp_r))
            susp_nxt = 1'b0; // [R11]
        else if (suspend_detect_enable_r && LINK_EVT.suspend && !inh_r)
            susp_nxt = 1'b1; // [R10]
        if (!susp_r && susp_nxt && irq_en_r[UFC_IRQ_SUSPEND])
            irq_set[UFC_IRQ_SUSPEND] = 1'b1; // [R10]
        if (susp_r && LINK_EVT.resume && irq_en_r[UFC_IRQ_RESUME])
            irq_set[UFC_IRQ_RESUME] = 1'b1; // [R12]
        // Resume is driven while force stays set after leaving suspend
        wake_nxt = force_r && (wake_r || susp_r); // [R19]
        // Flags clear on read; a coincident event still sets its flag
        irq_fl_nxt = irq_fl_r;
        if (acc && !HWRITE && (idx == UFC_IDX_IRQ_FLAGS))
            irq_fl_nxt = 3'h0;
        irq_fl_nxt = irq_fl_nxt | irq_set;
        // Bus reset overrides address, index and interrupt state; power bits other than suspended and the bus reset flag are kept
        if (brst_evt)
        begin
            addr_new_nxt = UFC_ADDR_RST; // [R07]
            addr_eff_nxt = UFC_ADDR_RST; // [R07]
            pend_nxt     = 1'b0;
            index_nxt    = UFC_INDEX_RST; // [R07]
            irq_en_nxt   = UFC_IRQ_EN_BRST; // [R08]
            irq_fl_nxt   = UFC_IRQ_FL_RST; // [R08]
            irq_fl_nxt[UFC_IRQ_RESET] = UFC_IRQ_EN_BRST[UFC_IRQ_RESET];
        end
        // Packets loaded after a SOF wait for the next one
        held_nxt = (held_r & ~{4{LINK_EVT.sof}}) |
                   ({4{iso_r}} & ISO_EP & PKT_LOADED); // [R14]
    end

    always_ff @(posedge CLK or negedge usb_rst_n)
    begin
        if (!usb_rst_n)
        begin
            addr_new_r <= UFC_ADDR_RST;
            addr_eff_r <= UFC_ADDR_RST;
            pend_r     <= 1'b0;
            iso_r      <= 1'b0;
            inh_r      <= 1'b1; // [R16] [R17]
            force_r    <= 1'b0;
            suspend_detect_enable_r    <= 1'b0;
            susp_r     <= 1'b0; // [R11]
            wake_r     <= 1'b0;
            brst_r     <= 1'b0;
            index_r    <= UFC_INDEX_RST;
            irq_en_r   <= UFC_IRQ_EN_RST;
            irq_fl_r   <= UFC_IRQ_FL_RST;
            held_r     <= 4'h0;
            zlp_r      <= 1'b0;
        end
        else
        begin
            addr_new_r <= addr_new_nxt;
            addr_eff_r <= addr_eff_nxt;
            pend_r     <= pend_nxt;
            iso_r      <= iso_nxt;
            inh_r      <= inh_nxt;
            force_r    <= force_nxt;
            suspend_detect_enable_r    <= suspend_detect_enable_nxt;
            susp_r     <= susp_nxt;
            wake_r     <= wake_nxt;
            brst_r     <= LINK_EVT.bus_reset; // [R06]
            index_r    <= index_nxt;
            irq_en_r   <= irq_en_nxt;
            irq_fl_r   <= irq_fl_nxt;
            held_r     <= held_nxt;
            zlp_r      <= IN_TOKEN.valid && held_r[IN_TOKEN.ep]; // [R15]
        end
    end

    // Link-side outputs, all from flip-flops except the reset pulse
    assign DEVICE_ADDR  = addr_eff_r;
    assign EP_INDEX     = index_r;
    assign CTRL_ENABLE  = !inh_r; // [R16]
    assign SUSPENDED    = susp_r;
    assign OSC_SUSPEND  = susp_r; // [R11]
    assign RESUME_DRIVE = wake_r; // [R19]
    assign EP_CSR_CLEAR = brst_evt; // [R07]
    assign TX_HOLD      = held_r;
    assign ZLP_REPLY    = zlp_r;

    AST_PEND_SET: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R05]
        wr_fa && !brst_evt |=> pend_r && addr_new_r == $past(HWDATA[6:0]))
        else $error("Pending flag not set after address write");
    AST_ADDR_HOLD: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R04]
        pend_r && !LINK_EVT.xfer_end && !brst_evt |=> $stable(DEVICE_ADDR))
        else $error("Address changed before transfer end");
    AST_ADDR_TAKE: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R04]
        pend_r && LINK_EVT.xfer_end && !wr_fa && !brst_evt
        |=> !pend_r && DEVICE_ADDR == addr_new_r)
        else $error("New address not taken at transfer end");
    AST_BRST_CLR: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R07]
        brst_evt |=> DEVICE_ADDR == 7'h00 && EP_INDEX == 4'h0 && TX_EMPTY == 4'hf)
        else $error("Bus reset did not clear address, index or FIFOs");
    AST_BRST_IRQ: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R08]
        brst_evt |=> irq_en_r == 3'h6 && irq_fl_r == 3'h4)
        else $error("Bus reset interrupt state wrong");
    AST_BRST_FLAG: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R06]
        LINK_EVT.bus_reset |=> brst_r)
        else $error("Bus reset flag not set");
    AST_INH_STICKY: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R17]
        !inh_r |=> !inh_r)
        else $error("Inhibit set again without a reset");
    AST_SOFT_RST: assert property (@(posedge CLK) disable iff (!RESETN) // [R09]
        wr_pw && HWDATA[UFC_PW_BUS_RST] |=> soft_r ##1 inh_r && !soft_r)
        else $error("Forced controller reset missing");
    AST_SUSP_IN: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R10]
        suspend_detect_enable_r && LINK_EVT.suspend && !inh_r && !susp_r && !force_r &&
        !brst_evt && !LINK_EVT.resume |=> susp_r)
        else $error("Suspend not entered");
    AST_RESUME: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R12]
        susp_r && LINK_EVT.resume && irq_en_r[UFC_IRQ_RESUME] && !brst_evt
        |=> !susp_r && irq_fl_r[UFC_IRQ_RESUME])
        else $error("Resume did not exit suspend or flag it");
    AST_ISO_HOLD: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R14]
        iso_r && |(ISO_EP & PKT_LOADED)
        |=> (TX_HOLD & $past(ISO_EP & PKT_LOADED)) ==
            $past(ISO_EP & PKT_LOADED))
        else $error("ISO packet not held until SOF");
    AST_ZLP: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R15]
        IN_TOKEN.valid && held_r[IN_TOKEN.ep] |=> ZLP_REPLY)
        else $error("Held ISO endpoint did not answer zero length");
    AST_ONE_BYTE: assert property (@(posedge CLK) disable iff (!usb_rst_n) // [R20]
        $onehot0(bus_pop) && $onehot0(bus_push))
        else $error("More than one FIFO moved by one access");

endmodule

// ---- test/ufc_host_model.sv ----
/*
 * Behavioural host and link side: bus events, IN tokens, FIFO traffic.
 * Assumes the bench calls send() from its main thread, one burst at a time.
 */
module ufc_host_model
    import ufc_pkg::*;
(
    input  wire logic       clk,
    output ufc_evt_t        evt,
    output ufc_tok_t        tok,
    output logic [3:0]      ld,
    output logic [3:0]      pop,
    output logic [3:0]      push,
    output logic [7:0]      rxd
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link at time zero
    initial
    begin
        evt = '0;
        tok = '0;
        ld = '0;
        pop = '0;
        push = '0;
        rxd = 8'h00;
    end

    // One burst held n cycles after an edge, then released
    task automatic send(input ufc_evt_t e, input ufc_tok_t t,
        input logic [3:0] l, p, s, input logic [7:0] d, input int n);
        @(posedge clk);
        evt <= e;
        tok <= t;
        ld <= l;
        pop <= p;
        push <= s;
        rxd <= d;
        repeat (n) @(posedge clk);
        evt <= '0;
        tok <= '0;
        ld <= '0;
        pop <= '0;
        push <= '0;
        rxd <= ~d;                  // Released data must not look valid
    endtask
endmodule

// ---- test/tb_usb_function_device_control.sv ----
/*
 * Self-checking bench of the device-control block over AHB-Lite.
 * Assumes zero-wait slave behaviour is discovered, never presumed.
 */
module tb_usb_function_device_control;
    import ufc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic CLK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP, HREADY;
    logic CTRL_ENABLE, SUSPENDED, OSC_SUSPEND, RESUME_DRIVE;
    logic EP_CSR_CLEAR, ZLP_REPLY;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0]  HTRANS;
    logic [3:0]  ISO_EP, PKT_LOADED, TX_POP, RX_PUSH, TX_EMPTY, RX_FULL;
    logic [3:0]  EP_INDEX, TX_HOLD;
    logic [7:0]  RX_DATA;
    logic [6:0]  DEVICE_ADDR;
    logic [3:0][7:0] TX_DATA;
    ufc_evt_t    LINK_EVT;
    ufc_tok_t    IN_TOKEN;
    int          n_fail, check_count;
    int          zlp_cnt = 0;
    int          csr_cnt = 0;

    assign HREADY = HREADYOUT;
    ufc_device_ctrl #(.FIFO_DEPTH(4)) dut (.CLK, .RESETN, .HSEL, .HADDR,
        .HTRANS, .HWRITE, .HWDATA, .HREADY, .HREADYOUT, .HRESP, .HRDATA,
        .LINK_EVT, .IN_TOKEN, .ISO_EP, .PKT_LOADED, .TX_POP, .RX_PUSH,
        .RX_DATA, .TX_DATA, .TX_EMPTY, .RX_FULL, .DEVICE_ADDR, .EP_INDEX,
        .CTRL_ENABLE, .SUSPENDED, .OSC_SUSPEND, .RESUME_DRIVE,
        .EP_CSR_CLEAR, .TX_HOLD, .ZLP_REPLY);
    ufc_host_model host (.clk(CLK), .evt(LINK_EVT), .tok(IN_TOKEN),
        .ld(PKT_LOADED), .pop(TX_POP), .push(RX_PUSH), .rxd(RX_DATA));

    // Pulse counters catch one-cycle outputs without edge races
    always @(posedge CLK)
    begin
        zlp_cnt <= zlp_cnt + (ZLP_REPLY === 1'b1);
        csr_cnt <= csr_cnt + (EP_CSR_CLEAR === 1'b1);
    end

    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("mismatches=%0d comparisons=%0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Bounded wait for hready at a rising edge
    task automatic hwait;
        int k;
        k = 0;
        do
        begin
            @(posedge CLK);
            k++;
        end
        while (HREADYOUT !== 1'b1 && k < 20);
        if (HREADYOUT !== 1'b1)
        begin
            n_fail++;
            final_report();
        end
    endtask

    // One single-word transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] i,
        input logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HADDR <= {22'h0, i, 2'b00};
        HWRITE <= w;
        HTRANS <= UFC_HTRANS_NONSEQ;
        hwait();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        hwait();
        rd = HRDATA;
        chk(HRESP, UFC_HRESP_OKAY);
    endtask

    task automatic rc(input logic [7:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        chk(rd, e);
    endtask

    task automatic st(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    // Stands in for the controller clock of the surrounding logic
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    initial
    begin
        {RESETN, HSEL, HWRITE, HTRANS, HADDR, HWDATA, ISO_EP} = '0;
        {n_fail, check_count} = '0;
        repeat (5) @(posedge CLK);
        RESETN <= 1'b1;
        rc(UFC_IDX_FUNC_ADDR, 32'h0);
        rc(UFC_IDX_POWER, 32'h10);
        chk(CTRL_ENABLE, 1'b0);
        bus(1'b1, UFC_IDX_POWER, 32'h08);
        st(2);
        bus(1'b1, UFC_IDX_IRQ_EN, 32'h07);
        bus(1'b1, UFC_IDX_POWER, 32'h00);
        st(0);
        chk(CTRL_ENABLE, 1'b1);
        bus(1'b1, UFC_IDX_POWER, 32'h10);
        rc(UFC_IDX_POWER, 32'h00);
        rc(8'h05, 32'h0);
        bus(1'b1, UFC_IDX_FUNC_ADDR, 32'h35);
        st(0);
        chk(DEVICE_ADDR, 7'h00);
        rc(UFC_IDX_FUNC_ADDR, 32'hb5);
        host.send(5'h01, '0, '0, '0, '0, 8'h00, 1);
        st(1);
        chk(DEVICE_ADDR, 7'h35);
        rc(UFC_IDX_FUNC_ADDR, 32'h35);
        for (int e = 0; e < 4; e++)
        begin
            bus(1'b1, UFC_IDX_FIFO_LO + 8'(e), 32'ha0 + e);
            st(0);
            chk(TX_EMPTY[e], 1'b0);
            host.send('0, '0, '0, 4'h1 << e, '0, 8'h00, 1);
            st(0);
            chk(TX_DATA[e], 8'ha0 + 8'(e));
            chk(TX_EMPTY[e], 1'b1);
            host.send('0, '0, '0, '0, 4'h1 << e, 8'h50 + 8'(e), 1);
            rc(UFC_IDX_FIFO_LO + 8'(e), 32'h50 + e);
        end
        bus(1'b1, UFC_IDX_POWER, 32'h01);
        host.send(5'h08, '0, '0, '0, '0, 8'h00, 1);
        st(1);
        chk({SUSPENDED, OSC_SUSPEND}, 2'b11);
        rc(UFC_IDX_IRQ_FLAGS, 32'h1);
        host.send(5'h04, '0, '0, '0, '0, 8'h00, 1);
        st(1);
        chk({SUSPENDED, OSC_SUSPEND}, 2'b00);
        rc(UFC_IDX_IRQ_FLAGS, 32'h2);
        host.send(5'h08, '0, '0, '0, '0, 8'h00, 1);
        bus(1'b1, UFC_IDX_POWER, 32'h05);
        st(1);
        chk({SUSPENDED, RESUME_DRIVE}, 2'b01);
        bus(1'b1, UFC_IDX_POWER, 32'h01);
        st(1);
        chk(RESUME_DRIVE, 1'b0);
        @(posedge CLK) ISO_EP <= 4'h2;
        bus(1'b1, UFC_IDX_POWER, 32'h81);
        host.send('0, '0, 4'h2, '0, '0, 8'h00, 1);
        st(1);
        chk(TX_HOLD, 4'h2);
        host.send('0, 3'h5, '0, '0, '0, 8'h00, 1);
        st(2);
        chk(zlp_cnt, 1);
        host.send(5'h02, '0, '0, '0, '0, 8'h00, 1);
        st(1);
        chk(TX_HOLD, 4'h0);
        host.send('0, '0, '0, '0, 4'h1, 8'h3c, 4);
        st(0);
        chk(RX_FULL, 4'h1);
        bus(1'b1, UFC_IDX_EP_INDEX, 32'h3);
        bus(1'b1, UFC_IDX_IRQ_EN, 32'h1);
        bus(1'b1, UFC_IDX_FIFO_LO, 32'h77);
        fork
            host.send(5'h10, '0, '0, '0, '0, 8'h00, 8);
            begin
                st(3);
                bus(1'b0, UFC_IDX_POWER, 32'h0);
                chk(rd & 32'h8, 32'h8);
            end
        join
        st(1);
        chk({DEVICE_ADDR, EP_INDEX, TX_EMPTY}, {7'h0, 4'h0, 4'hf});
        chk(csr_cnt, 1);
        chk(RX_FULL, 4'h0);
        rc(UFC_IDX_IRQ_EN, 32'h6);
        rc(UFC_IDX_IRQ_FLAGS, 32'h4);
        bus(1'b1, UFC_IDX_FUNC_ADDR, 32'h12);
        bus(1'b1, UFC_IDX_POWER, 32'h08);
        st(2);
        chk(CTRL_ENABLE, 1'b0);
        rc(UFC_IDX_POWER, 32'h10);
        rc(UFC_IDX_FUNC_ADDR, 32'h0);
        final_report();
    end
endmodule
